// >>> core/crw_window.sv
// Configuration register window: port registers, power, page, space map and lock status.
// Assumes MCU strobes synchronous to sys_clk; address latch captures on the strobe level.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RQ1] Decode 256-byte window at chosen base
// [RQ2] Input register reads live pin level
// [RQ3] Ports A/B mode selects I/O or address
// [RQ4] Output register drives pins set as outputs
// [RQ5] Direction register sets each pin's direction
// [RQ6] Drive register selects open drain or slew
// [RQ7] Read-only main flash sector lock at C0
// [RQ8] Read-only security and boot lock at C2
// [RQ9] Space map places areas per area
// [RQ10] Power registers B0, B4; page at E0
// [RQ11] Chip select high disables memory blocks
// [RQ12] Latch MCU address on the strobe
// [RQ13] MCU qualifies transfers with byte enable low
// [RQ14] Reset returns port and config registers
// [RQ15] Writes to read-only or unassigned ignored
module crw_window
  import crw_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Window placement
  input  wire logic [7:0]        window_base_hi,
  // MCU bus
  input  wire logic              address_latch_strobe,
  input  wire logic [ADDR_W-1:0] mcu_addr,
  input  wire logic              chip_select_n,
  input  wire logic              byte_enable_low,
  input  wire logic              byte_enable_used,
  input  wire logic              wr_n,
  input  wire logic              rd_n,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata,
  output logic                   rdata_oe,
  // Port pins
  input  wire logic [7:0]        port_a_in,
  input  wire logic [7:0]        port_b_in,
  input  wire logic [7:0]        port_c_in,
  input  wire logic [7:0]        port_d_in,
  output logic      [7:0]        port_a_out,
  output logic      [7:0]        port_a_oe,
  output logic      [7:0]        port_a_slew,
  output logic      [7:0]        port_b_out,
  output logic      [7:0]        port_b_oe,
  output logic      [7:0]        port_b_slew,
  output logic      [7:0]        port_c_out,
  output logic      [7:0]        port_c_oe,
  output logic      [7:0]        port_d_out,
  output logic      [7:0]        port_d_oe,
  // Status inputs from the flash and configuration
  input  wire logic [7:0]        main_flash_lock_in,
  input  wire logic [7:0]        security_lock_in,
  // Configuration outputs to the rest of the device
  output logic      [7:0]        power_control_0,
  output logic      [7:0]        power_control_2,
  output logic      [7:0]        memory_page_select,
  output logic      [7:0]        program_data_space_map,
  output logic                   memory_enable
);

  logic [1:0]        rst_sync_reg;
  logic              rst_n;
  logic [ADDR_W-1:0] latched_addr_reg;
  logic [ADDR_W-1:0] latched_addr_next;
  crw_port_cfg_t     cfg_a_reg, cfg_b_reg, cfg_c_reg, cfg_d_reg;
  logic [7:0]        pwr0_reg, pwr2_reg, page_reg, map_reg;
  crw_access_t       acc;
  wire logic         qualify;
  wire logic         in_window;
  logic [7:0]        rd_mux;

  // Reset release is synchronised so all registers leave reset on the same edge.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // The address is held from the strobe so a multiplexed bus can reuse the lines for data.
  assign latched_addr_next = address_latch_strobe ? mcu_addr : latched_addr_reg; // [RQ12]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_addr_reg <= 16'h0000;
    end else begin
      latched_addr_reg <= latched_addr_next;
    end
  end

  // When the byte enable pin is not in use, every transfer counts as qualified.
  assign qualify   = !byte_enable_used || !byte_enable_low; // [RQ13]
  assign in_window = (latched_addr_reg[15:8] == window_base_hi); // [RQ1]
  assign acc.sel   = !chip_select_n && qualify && in_window; // [RQ11]
  assign acc.wr    = acc.sel && !wr_n;
  assign acc.rd    = acc.sel && !rd_n;
  assign acc.ofs   = latched_addr_reg[7:0]; // [RQ1]
  assign acc.wdata = wdata;

  function automatic logic hit(input crw_access_t a, input logic [7:0] ofs);
    return a.wr && (a.ofs == ofs);
  endfunction : hit

  // Input, lock and unassigned offsets have no write path at all.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_a_reg <= {RST_PORT, RST_PORT, RST_PORT, RST_PORT}; // [RQ14]
      cfg_b_reg <= {RST_PORT, RST_PORT, RST_PORT, RST_PORT};
      cfg_c_reg <= {RST_PORT, RST_PORT, RST_PORT, RST_PORT};
      cfg_d_reg <= {RST_PORT, RST_PORT, RST_PORT, RST_PORT};
      pwr0_reg  <= RST_CFG;
      pwr2_reg  <= RST_CFG;
      page_reg  <= RST_CFG;
      map_reg   <= RST_CFG;
    end else begin // [RQ15]
      if (hit(acc, OFS_A_MODE)) cfg_a_reg.mode <= acc.wdata; // [RQ3]
      if (hit(acc, OFS_B_MODE)) cfg_b_reg.mode <= acc.wdata; // [RQ3]
      if (hit(acc, OFS_A_OUT))  cfg_a_reg.out  <= acc.wdata; // [RQ4]
      if (hit(acc, OFS_B_OUT))  cfg_b_reg.out  <= acc.wdata; // [RQ4]
      if (hit(acc, OFS_C_OUT))  cfg_c_reg.out  <= acc.wdata; // [RQ4]
      if (hit(acc, OFS_D_OUT))  cfg_d_reg.out  <= acc.wdata; // [RQ4]
      if (hit(acc, OFS_A_DIR))  cfg_a_reg.dir  <= acc.wdata; // [RQ5]
      if (hit(acc, OFS_B_DIR))  cfg_b_reg.dir  <= acc.wdata; // [RQ5]
      if (hit(acc, OFS_C_DIR))  cfg_c_reg.dir  <= acc.wdata; // [RQ5]
      if (hit(acc, OFS_D_DIR))  cfg_d_reg.dir  <= acc.wdata; // [RQ5]
      if (hit(acc, OFS_A_DRV))  cfg_a_reg.drv  <= acc.wdata; // [RQ6]
      if (hit(acc, OFS_B_DRV))  cfg_b_reg.drv  <= acc.wdata; // [RQ6]
      if (hit(acc, OFS_C_DRV))  cfg_c_reg.drv  <= acc.wdata; // [RQ6]
      if (hit(acc, OFS_D_DRV))  cfg_d_reg.drv  <= acc.wdata; // [RQ6]
      if (hit(acc, OFS_PWR0))   pwr0_reg       <= acc.wdata; // [RQ10]
      if (hit(acc, OFS_PWR2))   pwr2_reg       <= acc.wdata; // [RQ10]
      if (hit(acc, OFS_PAGE))   page_reg       <= acc.wdata; // [RQ10]
      if (hit(acc, OFS_MAP))    map_reg        <= acc.wdata; // [RQ9]
    end
  end

  // Read selection; unassigned offsets read as zero.
  always_comb begin
    case (acc.ofs)
      OFS_A_IN:    rd_mux = port_a_in; // [RQ2]
      OFS_B_IN:    rd_mux = port_b_in; // [RQ2]
      OFS_C_IN:    rd_mux = port_c_in; // [RQ2]
      OFS_D_IN:    rd_mux = port_d_in; // [RQ2]
      OFS_A_MODE:  rd_mux = cfg_a_reg.mode;
      OFS_B_MODE:  rd_mux = cfg_b_reg.mode;
      OFS_A_OUT:   rd_mux = cfg_a_reg.out;
      OFS_B_OUT:   rd_mux = cfg_b_reg.out;
      OFS_C_OUT:   rd_mux = cfg_c_reg.out;
      OFS_D_OUT:   rd_mux = cfg_d_reg.out;
      OFS_A_DIR:   rd_mux = cfg_a_reg.dir;
      OFS_B_DIR:   rd_mux = cfg_b_reg.dir;
      OFS_C_DIR:   rd_mux = cfg_c_reg.dir;
      OFS_D_DIR:   rd_mux = cfg_d_reg.dir;
      OFS_A_DRV:   rd_mux = cfg_a_reg.drv;
      OFS_B_DRV:   rd_mux = cfg_b_reg.drv;
      OFS_C_DRV:   rd_mux = cfg_c_reg.drv;
      OFS_D_DRV:   rd_mux = cfg_d_reg.drv;
      OFS_PWR0:    rd_mux = pwr0_reg;
      OFS_PWR2:    rd_mux = pwr2_reg;
      OFS_MFLOCK:  rd_mux = main_flash_lock_in; // [RQ7]
      OFS_SECLOCK: rd_mux = security_lock_in; // [RQ8]
      OFS_PAGE:    rd_mux = page_reg;
      OFS_MAP:     rd_mux = map_reg;
      default:     rd_mux = READ_ZERO;
    endcase
  end

  // In address-output mode the pin shows the latched low address byte instead of the data.
  function automatic logic [7:0] pin_value(input logic [7:0] mode, input logic [7:0] out,
                                           input logic [7:0] addr_byte);
    return (mode & addr_byte) | (~mode & out);
  endfunction : pin_value

  // Open-drain pins drive only lows; the pad releases for a one.
  function automatic logic [7:0] pin_enable(input logic [7:0] dir, input logic [7:0] mode,
                                            input logic [7:0] od, input logic [7:0] val);
    return (dir | mode) & ~(od & val);
  endfunction : pin_enable

  wire logic [7:0] a_val = pin_value(cfg_a_reg.mode, cfg_a_reg.out, latched_addr_reg[7:0]);
  wire logic [7:0] b_val = pin_value(cfg_b_reg.mode, cfg_b_reg.out, latched_addr_reg[7:0]);
  wire logic [7:0] a_od  = cfg_a_reg.drv & OD_CAPABLE_AB & ~cfg_a_reg.mode;
  wire logic [7:0] b_od  = cfg_b_reg.drv & OD_CAPABLE_AB & ~cfg_b_reg.mode;
  wire logic [7:0] c_od  = cfg_c_reg.drv & OD_CAPABLE_CD;
  wire logic [7:0] d_od  = cfg_d_reg.drv & OD_CAPABLE_CD;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata       <= READ_ZERO;
      rdata_oe    <= 1'b0;
      port_a_out  <= RST_PORT;
      port_a_oe   <= RST_PORT;
      port_a_slew <= RST_PORT;
      port_b_out  <= RST_PORT;
      port_b_oe   <= RST_PORT;
      port_b_slew <= RST_PORT;
      port_c_out  <= RST_PORT;
      port_c_oe   <= RST_PORT;
      port_d_out  <= RST_PORT;
      port_d_oe   <= RST_PORT;
      power_control_0        <= RST_CFG;
      power_control_2        <= RST_CFG;
      memory_page_select     <= RST_CFG;
      program_data_space_map <= RST_CFG;
      memory_enable          <= 1'b0;
    end else begin
      rdata       <= acc.rd ? rd_mux : READ_ZERO;
      rdata_oe    <= acc.rd;
      port_a_out  <= a_val; // [RQ3]
      port_a_oe   <= pin_enable(cfg_a_reg.dir, cfg_a_reg.mode, a_od, a_val); // [RQ4]
      port_a_slew <= cfg_a_reg.drv & ~OD_CAPABLE_AB; // [RQ6]
      port_b_out  <= b_val; // [RQ3]
      port_b_oe   <= pin_enable(cfg_b_reg.dir, cfg_b_reg.mode, b_od, b_val); // [RQ4]
      port_b_slew <= cfg_b_reg.drv & ~OD_CAPABLE_AB; // [RQ6]
      port_c_out  <= cfg_c_reg.out;
      port_c_oe   <= pin_enable(cfg_c_reg.dir, RST_PORT, c_od, cfg_c_reg.out); // [RQ5]
      port_d_out  <= cfg_d_reg.out;
      port_d_oe   <= pin_enable(cfg_d_reg.dir, RST_PORT, d_od, cfg_d_reg.out); // [RQ5]
      power_control_0        <= pwr0_reg;
      power_control_2        <= pwr2_reg;
      memory_page_select     <= page_reg;
      program_data_space_map <= map_reg; // [RQ9]
      memory_enable          <= !chip_select_n; // [RQ11]
    end
  end

endmodule : crw_window

`default_nettype wire

// >>> core/crw_pkg.sv
// Package for the configuration register window: offsets, field layouts, reset values.
// Assumes an 8-bit MCU bus with multiplexed or separate address and data lines.
package crw_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Window base is compared on the upper address byte; the lower byte is the offset.
  localparam logic [7:0] WINDOW_BASE_HI_DEFAULT = 8'hf0;

  localparam logic [7:0] OFS_A_IN    = 8'h00;
  localparam logic [7:0] OFS_B_IN    = 8'h01;
  localparam logic [7:0] OFS_A_MODE  = 8'h02;
  localparam logic [7:0] OFS_B_MODE  = 8'h03;
  localparam logic [7:0] OFS_A_OUT   = 8'h04;
  localparam logic [7:0] OFS_B_OUT   = 8'h05;
  localparam logic [7:0] OFS_A_DIR   = 8'h06;
  localparam logic [7:0] OFS_B_DIR   = 8'h07;
  localparam logic [7:0] OFS_A_DRV   = 8'h08;
  localparam logic [7:0] OFS_B_DRV   = 8'h09;
  localparam logic [7:0] OFS_C_IN    = 8'h10;
  localparam logic [7:0] OFS_D_IN    = 8'h11;
  localparam logic [7:0] OFS_C_OUT   = 8'h12;
  localparam logic [7:0] OFS_D_OUT   = 8'h13;
  localparam logic [7:0] OFS_C_DIR   = 8'h14;
  localparam logic [7:0] OFS_D_DIR   = 8'h15;
  localparam logic [7:0] OFS_C_DRV   = 8'h16;
  localparam logic [7:0] OFS_D_DRV   = 8'h17;
  localparam logic [7:0] OFS_PWR0    = 8'hb0;
  localparam logic [7:0] OFS_PWR2    = 8'hb4;
  localparam logic [7:0] OFS_MFLOCK  = 8'hc0;
  localparam logic [7:0] OFS_SECLOCK = 8'hc2;
  localparam logic [7:0] OFS_PAGE    = 8'he0;
  localparam logic [7:0] OFS_MAP     = 8'he2;

  localparam logic [7:0] RST_PORT    = 8'h00;
  localparam logic [7:0] RST_CFG     = 8'h00;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // On ports A and B only the upper nibble can be open drain; the lower one gets slew control.
  localparam logic [7:0] OD_CAPABLE_AB = 8'hf0;
  localparam logic [7:0] OD_CAPABLE_CD = 8'hff;

  // Per-port settings carried as one bundle.
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] out;
    logic [7:0] dir;
    logic [7:0] drv;
  } crw_port_cfg_t;

  // One MCU bus cycle as seen by the window.
  typedef struct packed {
    logic              sel;
    logic              wr;
    logic              rd;
    logic [7:0]        ofs;
    logic [DATA_W-1:0] wdata;
  } crw_access_t;

endpackage : crw_pkg

// >>> verif/crw_window_sva.sv
// Checker for the register window: access blocking and register update timing.
// Assumes it is bound to crw_window and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module crw_window_sva
  import crw_pkg::*;
(
  // Clock, reset and placement
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic [7:0]        window_base_hi,
  // MCU bus
  input wire logic              address_latch_strobe,
  input wire logic [ADDR_W-1:0] mcu_addr,
  input wire logic              chip_select_n,
  input wire logic              byte_enable_low,
  input wire logic              byte_enable_used,
  input wire logic              wr_n,
  input wire logic              rd_n,
  input wire logic [7:0]        wdata,
  input wire logic [7:0]        rdata,
  input wire logic              rdata_oe,
  // Watched pins and outputs
  input wire logic [7:0]        port_c_in,
  input wire logic [7:0]        port_a_slew,
  input wire logic [7:0]        power_control_2,
  input wire logic [7:0]        memory_page_select,
  input wire logic              memory_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [ADDR_W-1:0] lat_q;
  // Own copy of the latched address, so the checker knows where an access lands.
  always_ff @(posedge sys_clk) begin
    if (address_latch_strobe) begin
      lat_q <= mcu_addr;
    end
  end
  wire qual = !chip_select_n && (!byte_enable_used || !byte_enable_low);
  wire hit  = qual && lat_q[15:8] == window_base_hi;
  // Configuration outputs are a second flop behind the register, so writes show two edges later.
  page_write_a: assert property (hit && !wr_n && lat_q[7:0] == OFS_PAGE
    |=> ##1 memory_page_select == $past(wdata, 2)) else $error("page write lost");
  pin_read_a: assert property (hit && !rd_n && lat_q[7:0] == OFS_C_IN
    |=> rdata_oe && rdata == $past(port_c_in)) else $error("pin read wrong");
  outside_ignored_a: assert property (!wr_n && lat_q[15:8] != window_base_hi
    |=> ##1 $stable(memory_page_select)) else $error("write outside window taken");
  cs_blocks_a: assert property (chip_select_n
    |=> !rdata_oe ##1 ($stable(power_control_2) && $stable(memory_page_select)))
    else $error("access with select high");
  mem_enable_a: assert property ($changed(chip_select_n)
    |=> memory_enable == !$past(chip_select_n)) else $error("memory enable late");
  read_only_a: assert property (rd_n |=> !rdata_oe) else $error("read data without read");
  read_idle_a: assert property (!rdata_oe |-> rdata == READ_ZERO) else $error("idle data");
  slew_low_a: assert property (port_a_slew[7:4] == 4'h0) else $error("slew on upper pins");
endmodule : crw_window_sva
bind crw_window crw_window_sva crw_window_sva_inst (.sys_clk, .arst_n, .window_base_hi,
  .address_latch_strobe, .mcu_addr, .chip_select_n, .byte_enable_low, .byte_enable_used,
  .wr_n, .rd_n, .wdata, .rdata, .rdata_oe, .port_c_in, .port_a_slew, .power_control_2,
  .memory_page_select, .memory_enable);
`default_nettype wire

// >>> verif/crw_mcu_model.sv
// Model of the 8-bit MCU that reaches the register window.
// Assumes one byte per bus cycle, strobes changed only at falling edges.
`timescale 1ns/1ps
`default_nettype none
module crw_mcu_model
  import crw_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Bus driven by the MCU
  output logic                   address_latch_strobe,
  output logic      [ADDR_W-1:0] mcu_addr,
  output logic                   chip_select_n,
  output logic                   byte_enable_low,
  output logic                   wr_n,
  output logic                   rd_n,
  output logic      [7:0]        wdata,
  // Read return
  input  wire logic [7:0]        rdata
);
  logic [7:0] hi = WINDOW_BASE_HI_DEFAULT;
  // Set to leave the byte enable high, so the window must ignore the transfer.
  logic       be_skip = 1'b0;
  initial begin
    address_latch_strobe = 1'b0;
    mcu_addr = '0;
    chip_select_n = 1'b0;
    byte_enable_low = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    wdata = 8'h00;
  end
  task automatic cyc(input logic [7:0] ofs, input logic wr, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge sys_clk);
    address_latch_strobe = 1'b1;
    mcu_addr = {hi, ofs};
    @(negedge sys_clk);
    address_latch_strobe = 1'b0;
    byte_enable_low = be_skip;
    wr_n = !wr;
    rd_n = wr;
    wdata = d;
    @(negedge sys_clk);
    q = rdata;
    wr_n = 1'b1;
    rd_n = 1'b1;
    byte_enable_low = 1'b1;
    // Released data lines flip so a stale byte never looks valid.
    wdata = ~wdata;
  endtask : cyc
endmodule : crw_mcu_model
`default_nettype wire

// >>> verif/config_register_window_tb_top.sv
// Testbench for the register window: register map, pin paths and access blocking.
// Assumes the MCU model drives the bus; the bench drives pins, status and reset.
`timescale 1ns/1ps
`default_nettype none
module config_register_window_tb_top
  import crw_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic be_used = 1'b0;
  logic [7:0] pin_a = 8'h00, pin_b = 8'h00, pin_c = 8'h00, pin_d = 8'h00;
  logic [7:0] mf_lock = 8'h00, sec_lock = 8'h00;
  logic [7:0] rdata, wdata, pa_out, pa_oe, pb_out, pb_oe, pb_slew, pc_out, pc_oe, pd_out;
  logic [7:0] pd_oe, pw0, pw2, page, vmap;
  logic       strobe, cs_n, be_n, wr_n, rd_n, mem_en;
  logic [ADDR_W-1:0] addr;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] rw_ofs [18] = '{OFS_A_MODE, OFS_B_MODE, OFS_A_OUT, OFS_B_OUT, OFS_A_DIR,
    OFS_B_DIR, OFS_A_DRV, OFS_B_DRV, OFS_C_OUT, OFS_D_OUT, OFS_C_DIR, OFS_D_DIR,
    OFS_C_DRV, OFS_D_DRV, OFS_PWR0, OFS_PWR2, OFS_PAGE, OFS_MAP};
  always #50 sys_clk = ~sys_clk;
  crw_mcu_model crw_mcu_model_inst (.sys_clk, .address_latch_strobe(strobe),
    .mcu_addr(addr), .chip_select_n(cs_n), .byte_enable_low(be_n), .wr_n, .rd_n, .wdata,
    .rdata);
  crw_window crw_window_inst (.sys_clk, .arst_n, .window_base_hi(WINDOW_BASE_HI_DEFAULT),
    .address_latch_strobe(strobe), .mcu_addr(addr), .chip_select_n(cs_n),
    .byte_enable_low(be_n), .byte_enable_used(be_used), .wr_n, .rd_n, .wdata, .rdata,
    .rdata_oe(), .port_a_in(pin_a), .port_b_in(pin_b), .port_c_in(pin_c),
    .port_d_in(pin_d), .port_a_out(pa_out), .port_a_oe(pa_oe), .port_a_slew(),
    .port_b_out(pb_out), .port_b_oe(pb_oe), .port_b_slew(pb_slew), .port_c_out(pc_out),
    .port_c_oe(pc_oe), .port_d_out(pd_out), .port_d_oe(pd_oe), .main_flash_lock_in(mf_lock),
    .security_lock_in(sec_lock), .power_control_0(pw0), .power_control_2(pw2),
    .memory_page_select(page), .program_data_space_map(vmap), .memory_enable(mem_en));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    crw_mcu_model_inst.cyc(ofs, 1'b1, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] q;
    crw_mcu_model_inst.cyc(ofs, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask : rd_chk
  task automatic t_regs;
    for (int i = 0; i < 18; i++) begin
      rd_chk(rw_ofs[i], RST_PORT);
      wr(rw_ofs[i], rw_ofs[i] ^ 8'h5a);
    end
    for (int i = 0; i < 18; i++) begin
      rd_chk(rw_ofs[i], rw_ofs[i] ^ 8'h5a);
    end
    chk(pw0, OFS_PWR0 ^ 8'h5a);
    chk(pw2, OFS_PWR2 ^ 8'h5a);
    chk(vmap, OFS_MAP ^ 8'h5a);
    $display("register map test done");
  endtask : t_regs
  task automatic t_status;
    pin_a = 8'h11;
    pin_b = 8'h22;
    pin_c = 8'h33;
    pin_d = 8'h44;
    mf_lock = 8'h0f;
    sec_lock = 8'h81;
    rd_chk(OFS_A_IN, 8'h11);
    rd_chk(OFS_B_IN, 8'h22);
    rd_chk(OFS_C_IN, 8'h33);
    rd_chk(OFS_D_IN, 8'h44);
    rd_chk(OFS_MFLOCK, 8'h0f);
    rd_chk(OFS_SECLOCK, 8'h81);
    wr(OFS_MFLOCK, 8'hff);
    wr(8'h20, 8'hff);
    wr(OFS_C_IN, 8'hff);
    rd_chk(OFS_MFLOCK, 8'h0f);
    rd_chk(8'h20, READ_ZERO);
    rd_chk(OFS_C_IN, 8'h33);
    $display("status test done");
  endtask : t_status
  task automatic t_pins;
    wr(OFS_C_DRV, 8'h00);
    wr(OFS_C_DIR, 8'hf0);
    wr(OFS_C_OUT, 8'ha5);
    wr(OFS_D_DRV, 8'h0f);
    wr(OFS_D_DIR, 8'hff);
    wr(OFS_D_OUT, 8'h05);
    wr(OFS_B_MODE, 8'h00);
    wr(OFS_B_DIR, 8'hff);
    wr(OFS_B_DRV, 8'h3c);
    wr(OFS_B_OUT, 8'h5a);
    @(negedge sys_clk);
    chk(pc_out, 8'ha5);
    chk(pc_oe, 8'hf0);
    chk(pd_out, 8'h05);
    chk(pd_oe, 8'hfa);
    chk(pb_out, 8'h5a);
    chk(pb_oe, 8'hef);
    chk(pb_slew, 8'h0c);
    wr(OFS_A_DRV, 8'h00);
    wr(OFS_A_DIR, 8'h00);
    wr(OFS_A_MODE, 8'hff);
    @(negedge sys_clk);
    chk(pa_out, OFS_A_MODE);
    chk(pa_oe, 8'hff);
    $display("pin test done");
  endtask : t_pins
  task automatic t_block;
    be_used = 1'b1;
    wr(OFS_PAGE, 8'h3c);
    rd_chk(OFS_PAGE, 8'h3c);
    crw_mcu_model_inst.be_skip = 1'b1;
    wr(OFS_PAGE, 8'h99);
    rd_chk(OFS_PAGE, READ_ZERO);
    crw_mcu_model_inst.be_skip = 1'b0;
    rd_chk(OFS_PAGE, 8'h3c);
    crw_mcu_model_inst.hi = 8'h12;
    wr(OFS_PAGE, 8'h99);
    crw_mcu_model_inst.hi = WINDOW_BASE_HI_DEFAULT;
    // A taken write would reach the page output two edges after the access.
    repeat (2) @(negedge sys_clk);
    chk(page, 8'h3c);
    crw_mcu_model_inst.chip_select_n = 1'b1;
    @(negedge sys_clk);
    chk({7'h00, mem_en}, 8'h00);
    wr(OFS_PAGE, 8'h99);
    rd_chk(OFS_PAGE, READ_ZERO);
    crw_mcu_model_inst.chip_select_n = 1'b0;
    @(negedge sys_clk);
    chk({7'h00, mem_en}, 8'h01);
    rd_chk(OFS_PAGE, 8'h3c);
    $display("blocking test done");
  endtask : t_block
  task automatic t_reset;
    arst_n = 1'b0;
    @(negedge sys_clk);
    chk(page, RST_CFG);
    chk(pc_oe, RST_PORT);
    arst_n = 1'b1;
    // The window leaves reset two edges after release; one more edge of margin.
    repeat (3) @(negedge sys_clk);
    rd_chk(OFS_PAGE, RST_CFG);
    rd_chk(OFS_C_DIR, RST_PORT);
    $display("reset test done");
  endtask : t_reset
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_regs();
    t_status();
    t_pins();
    t_block();
    t_reset();
    results();
  end
  // Whole run is a few hundred cycles; ten thousand means a hang.
  initial begin
    #1000000;
    miscompares++;
    results();
  end
endmodule : config_register_window_tb_top
`default_nettype wire
